// File: core/watchdog_pkg.sv
// Constants shared by the low-frequency watchdog: register map, fields, resets, timing
package watchdog_pkg;
    localparam logic [7:0]  CTRL_OFFSET        = 8'h00;
    localparam logic [7:0]  RESTART_OFFSET     = 8'h04;
    localparam logic [7:0]  COUNT_OFFSET       = 8'h08;
    localparam logic [7:0]  IRQ_STATUS_OFFSET  = 8'h0C;
    localparam logic [7:0]  IRQ_MASK_OFFSET    = 8'h10;

    localparam int          CTRL_ENABLE_BIT    = 0;
    localparam int          CTRL_LOCK_BIT      = 1;
    localparam int          CTRL_SEL_LSB       = 2;
    localparam int          SEL_WIDTH          = 3;
    localparam int          RESTART_BIT        = 0;
    localparam int          EVT_TIMEOUT_BIT    = 0;
    localparam int          EVT_LOCKED_BIT     = 1;
    localparam int          EVT_WIDTH          = 2;
    localparam int          COUNT_WIDTH        = 24;

    localparam logic                 ENABLE_RESET = 1'b1;
    localparam logic                 LOCK_RESET   = 1'b0;
    localparam logic [SEL_WIDTH-1:0] SEL_RESET    = 3'h7;
    localparam logic [EVT_WIDTH-1:0] MASK_RESET   = 2'h0;

    localparam int          TIMEOUT_BASE_LOG2  = 13;
    localparam int          RESET_PULSE_NS     = 320;
    localparam int          CLK_PERIOD_NS      = 20;
    localparam int          RESET_PULSE_CYCLES = RESET_PULSE_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        HTRANS_IDLE,
        HTRANS_BUSY,
        HTRANS_NONSEQ,
        HTRANS_SEQ
    } htrans_t;
endpackage : watchdog_pkg

// File: core/watchdog_unit.sv
// Low-frequency watchdog counter with AHB-Lite register access
// Function
// - count advances only on rising low-frequency oscillator edges, not system clock.
// - overflow while enabled raises the system reset request.
// - after reset: enabled, counting, longest interval selected.
// - software may disable the counter while unlocked; no overflow afterwards.
// - once locked, configuration writes are ignored until the next reset.
// - watchdog reset never drives the external reset pin.
`timescale 1ns/1ps
module watchdog_unit #(
    parameter int BASE_LOG2 = watchdog_pkg::TIMEOUT_BASE_LOG2
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        low_freq_oscillator,
    output logic             system_reset_req,
    output logic             reset_pin_oe,
    output logic             irq
);
    import watchdog_pkg::*;

    // Oscillator synchroniser and edge detection
    logic                   lfo_meta;
    logic                   lfo_sync;
    logic                   lfo_prev;
    logic                   lfo_tick;

    // Configuration and the running count
    logic                   enable;
    logic                   lock;
    logic [SEL_WIDTH-1:0]   sel;
    logic [COUNT_WIDTH-1:0] count;
    logic [COUNT_WIDTH-1:0] next_count;
    logic                   overflow;
    logic [4:0]             pulse_cnt;

    // Interrupt status and mask
    logic [EVT_WIDTH-1:0]   irq_status;
    logic [EVT_WIDTH-1:0]   next_status;
    logic [EVT_WIDTH-1:0]   irq_mask;
    logic [EVT_WIDTH-1:0]   evt;

    // Bus address and data phase
    logic                   addr_take;
    logic                   wr_pending;
    logic [7:0]             wr_addr;
    logic                   wr_ctrl;
    logic                   wr_restart;
    logic                   wr_clear;
    logic                   wr_mask;
    logic [31:0]            next_rdata;

    function automatic logic [COUNT_WIDTH-1:0] limit_of(input logic [SEL_WIDTH-1:0] s);
        logic [COUNT_WIDTH:0] one;
        one = '0;
        one[0] = 1'b1;
        limit_of = COUNT_WIDTH'((one << (BASE_LOG2 + int'(s))) - 1'b1);
    endfunction : limit_of

    function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
        hits = (addr == offset);
    endfunction : hits

    // Oscillator pin is asynchronous to hclk; only lfo_sync leaves this pair
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lfo_meta <= 1'b0;
            lfo_sync <= 1'b0;
        end else begin
            lfo_meta <= low_freq_oscillator;
            lfo_sync <= lfo_meta;
        end
    end

    // Previous level for edge detection; hclk must be well above the oscillator rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lfo_prev <= 1'b0;
        end else begin
            lfo_prev <= lfo_sync;
        end
    end

    assign lfo_tick = lfo_sync & ~lfo_prev;

    // Transfer size is not decoded; every register is one whole word
    assign addr_take  = hsel & hready & htrans[1];
    assign wr_ctrl    = wr_pending && hits(wr_addr, CTRL_OFFSET);
    assign wr_restart = wr_pending && hits(wr_addr, RESTART_OFFSET) && hwdata[RESTART_BIT];
    assign wr_clear   = wr_pending && hits(wr_addr, IRQ_STATUS_OFFSET);
    assign wr_mask    = wr_pending && hits(wr_addr, IRQ_MASK_OFFSET);
    assign overflow   = enable & lfo_tick & (count >= limit_of(sel));

    // Write seen in the address phase, acted on in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
        end else begin
            wr_pending <= addr_take & hwrite;
        end
    end

    // Address kept for the data phase, when hwdata arrives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr <= 8'h00;
        end else begin
            wr_addr <= haddr[7:0];
        end
    end

    // Single-cycle data phase, so hreadyout stays high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // No transfer is refused, so every answer is OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (haddr[7:0])
            CTRL_OFFSET: begin
                next_rdata[CTRL_ENABLE_BIT] = enable;
                next_rdata[CTRL_LOCK_BIT] = lock;
                next_rdata[CTRL_SEL_LSB +: SEL_WIDTH] = sel;
            end
            COUNT_OFFSET:      next_rdata[COUNT_WIDTH-1:0] = count;
            IRQ_STATUS_OFFSET: next_rdata[EVT_WIDTH-1:0] = irq_status;
            IRQ_MASK_OFFSET:   next_rdata[EVT_WIDTH-1:0] = irq_mask;
            default:           next_rdata = 32'h0000_0000;
        endcase
    end

    // Captured in the address phase, held until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Enable comes back set after every reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable <= ENABLE_RESET;
        end else if (wr_ctrl && !lock) begin
            enable <= hwdata[CTRL_ENABLE_BIT];
        end
    end

    // Lock can only be left by a reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock <= LOCK_RESET;
        end else if (wr_ctrl && !lock) begin
            lock <= hwdata[CTRL_LOCK_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel <= SEL_RESET;
        end else if (wr_ctrl && !lock) begin
            sel <= hwdata[CTRL_SEL_LSB +: SEL_WIDTH];
        end
    end

    // Restart is honoured even when locked; lock guards configuration only
    always_comb begin
        next_count = count;
        if (wr_restart || overflow || !enable) begin
            next_count = '0;
        end else if (lfo_tick) begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // Stretched so slow reset logic downstream cannot miss it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_cnt <= '0;
        end else if (overflow) begin
            pulse_cnt <= 5'(RESET_PULSE_CYCLES);
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 1'b1;
        end
    end

    // High on the overflow edge and while more than one count remains
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            system_reset_req <= 1'b0;
        end else begin
            system_reset_req <= overflow || pulse_cnt > 5'd1;
        end
    end

    // Pin is left to its own drivers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_pin_oe <= 1'b0;
        end else begin
            reset_pin_oe <= 1'b0;
        end
    end

    // Events that set the sticky status bits
    always_comb begin
        evt = '0;
        evt[EVT_TIMEOUT_BIT] = overflow;
        evt[EVT_LOCKED_BIT]  = wr_ctrl & lock;
    end

    // Set wins over a same-cycle write-one-to-clear
    always_comb begin
        next_status = irq_status;
        if (wr_clear) begin
            next_status = irq_status & ~hwdata[EVT_WIDTH-1:0];
        end
        next_status = next_status | evt;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_status;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= MASK_RESET;
        end else if (wr_mask) begin
            irq_mask <= hwdata[EVT_WIDTH-1:0];
        end
    end

    // Uses the status before a same-cycle clear, so irq lags a clear by one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_status | evt) & irq_mask);
        end
    end
endmodule : watchdog_unit

// File: verif/watchdog_unit_props.sv
// Checker for the watchdog bus answers and reset-request outputs
`timescale 1ns/1ps
module watchdog_unit_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        system_reset_req,
    input wire logic        reset_pin_oe
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Sixteen cycles of request, split because repetition stays small
    sequence s_req_hold;
        system_reset_req [*8] ##1 system_reset_req [*8];
    endsequence
    property p_pulse;
        $rose(system_reset_req) |-> s_req_hold ##1 !system_reset_req;
    endproperty
    property p_pin;
        reset_pin_oe == 1'b0;
    endproperty
    property p_ready;
        hreadyout == 1'b1;
    endproperty
    property p_okay;
        hresp == 1'b0;
    endproperty
    property p_hold;
        !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata);
    endproperty
    // A fresh count after reset cannot overflow within a few cycles
    sequence s_quiet;
        !system_reset_req [*8];
    endsequence
    property p_quiet_start;
        $rose(hresetn) |-> s_quiet;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset request width wrong");
    a_pin:   assert property (p_pin) else $error("reset pin driven");
    a_ready: assert property (p_ready) else $error("wait state inserted");
    a_okay:  assert property (p_okay) else $error("error response");
    a_hold:  assert property (p_hold) else $error("read data moved");
    a_quiet_start: assert property (p_quiet_start) else $error("early reset request");
endmodule : watchdog_unit_props
bind watchdog_unit watchdog_unit_props u_watchdog_unit_props (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .system_reset_req(system_reset_req),
    .reset_pin_oe(reset_pin_oe));

// File: verif/tb_top.sv
// Self-checking bench for the low-frequency watchdog
`timescale 1ns/1ps
module tb_top;
    import watchdog_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = HTRANS_IDLE;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        low_freq_oscillator = 1'b0;
    logic        osc_run = 1'b0;
    logic        rst_seen = 1'b0;
    logic [1:0]  div = 2'h0;
    logic        hreadyout, hresp, system_reset_req, reset_pin_oe, irq;
    logic [31:0] hrdata, rd;
    int          err_count = 0, samples_checked = 0, cycles = 0;
    watchdog_unit #(.BASE_LOG2(2)) u_watchdog_unit (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .low_freq_oscillator(low_freq_oscillator),
        .system_reset_req(system_reset_req), .reset_pin_oe(reset_pin_oe), .irq(irq));
    always #10 hclk = ~hclk;
    // Oscillator phases of three cycles, only while a scenario asks
    always @(posedge hclk) begin
        if (osc_run) begin
            div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
            if (div == 2'h2) low_freq_oscillator <= ~low_freq_oscillator;
        end
    end
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (system_reset_req) rst_seen <= 1'b1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            finish_test();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= wd;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        rd = hrdata;
    endtask : ahb
    task t_reset;
        ahb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h0000_001D);
        ahb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0000_0000);
    endtask : t_reset
    task t_restart;
        ahb(1'b1, CTRL_OFFSET, 32'h0000_0001);
        osc_run <= 1'b1;
        repeat (6) begin
            repeat (12) @(posedge hclk);
            ahb(1'b1, RESTART_OFFSET, 32'h0000_0001);
        end
        check({31'h0, rst_seen}, 32'h0);
        osc_run <= 1'b0;
        ahb(1'b1, RESTART_OFFSET, 32'h0000_0001);
        ahb(1'b0, COUNT_OFFSET, 32'h0);
        check(rd, 32'h0);
    endtask : t_restart
    task t_overflow;
        ahb(1'b1, IRQ_MASK_OFFSET, 32'h0000_0001);
        osc_run <= 1'b1;
        for (int i = 0; i < 200 && !system_reset_req; i++) @(posedge hclk);
        check({31'h0, system_reset_req}, 32'h1);
        osc_run <= 1'b0;
        @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        ahb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        check(rd, 32'h1);
        ahb(1'b1, IRQ_STATUS_OFFSET, 32'h0000_0001);
        ahb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask : t_overflow
    task t_disable;
        ahb(1'b1, CTRL_OFFSET, 32'h0);
        // Let the earlier reset pulse run out before watching for a new one
        while (system_reset_req) @(posedge hclk);
        @(posedge hclk);
        rst_seen <= 1'b0;
        osc_run <= 1'b1;
        repeat (100) @(posedge hclk);
        check({31'h0, rst_seen}, 32'h0);
        ahb(1'b0, COUNT_OFFSET, 32'h0);
        check(rd, 32'h0);
    endtask : t_disable
    task t_lock;
        ahb(1'b1, CTRL_OFFSET, 32'h0000_0003);
        ahb(1'b1, CTRL_OFFSET, 32'h0);
        ahb(1'b0, CTRL_OFFSET, 32'h0);
        check(rd, 32'h3);
        ahb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
        check(rd, 32'h2);
        rst_seen <= 1'b0;
        repeat (60) @(posedge hclk);
        check({31'h0, rst_seen}, 32'h1);
        check({31'h0, reset_pin_oe}, 32'h0);
    endtask : t_lock
    task finish_test;
        $display("errors=%0d checks=%0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_restart();
        t_overflow();
        t_disable();
        t_lock();
        finish_test();
    end
endmodule : tb_top
